//--- design/pwf_dev_end.sv
/*
 * Device end: process RAM write FIFO with indexed registers, and the
 * direct-mapped 8/16-bit microcontroller path, both onto one core port.
 * Assumes the host holds strobes until busy is low and the core answers
 * each request with a one-cycle ack.
 */
// Chosen here: the strobed register port.
`include "pwf_regs.svh"
`default_nettype none

module pwf_dev_end
   import pwf_pkg::*;
#(
   parameter int DEPTH = `PWF_FIFO_DEPTH
) (
   input wire logic clk_i,
   input wire logic srst_i,
   pwf_link_if.dev link,
   input wire logic [1:0] iface_sel_i,
   input wire logic posted_wr_i,
   input wire logic [3:0] rd_wait_i,
   output logic core_req_o,
   output logic core_we_o,
   output logic [15:0] core_addr_o,
   output logic [3:0] core_be_o,
   output logic [31:0] core_wdata_o,
   input wire logic core_ack_i,
   input wire logic [31:0] core_rdata_i,
   output logic [7:0] err_count_o,
   output logic [7:0] err_code_o
);
   localparam int PW = $clog2(DEPTH);

   // Lanes from start lane, limited by bytes left
   function automatic logic [3:0] lane_mask(input logic [1:0] a, input logic [15:0] len);
      logic [2:0] room;
      logic [2:0] n;
      room = 3'd4 - {1'b0, a};
      n = (len < {13'h0000, room}) ? len[2:0] : room;
      lane_mask = 4'((5'h01 << n) - 5'h01) << a;
   endfunction

   function automatic logic [2:0] ones(input logic [3:0] m);
      ones = {2'b00, m[0]} + {2'b00, m[1]} + {2'b00, m[2]} + {2'b00, m[3]};
   endfunction

   // Direct-mapped lane decode, zero for the invalid combination
   function automatic logic [3:0] dm_lanes(input logic w16, input logic [1:0] a,
         input logic hbe_n);
      dm_lanes = 4'h0;
      if (!w16) begin
         dm_lanes = 4'h1 << a;
      end else begin
         case ({a[0], hbe_n})
            2'b00: dm_lanes = 4'h3 << {a[1], 1'b0};
            2'b01: dm_lanes = 4'h1 << {a[1], 1'b0};
            2'b10: dm_lanes = 4'h2 << {a[1], 1'b0};
            default: dm_lanes = 4'h0;
         endcase
      end
   endfunction

   logic [31:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_q;
   logic [PW-1:0] rd_ptr_q;
   logic [PW:0] cnt_q;
   logic [15:0] cur_addr_q;
   logic [15:0] cur_len_q;
   logic xfer_busy_q;
   logic strobe_q;
   logic want_q;
   logic busy_q;
   logic abandon_q;
   logic acc_we_q;
   logic [15:0] acc_addr_q;
   logic acc_hbe_n_q;
   logic [31:0] acc_wdata_q;
   pwf_dm_state_t dm_state_q;
   logic [3:0] wait_cnt_q;
   logic [31:0] rdata_q;
   logic from_drain_q;
   logic [7:0] err_cnt_q;
   logic [7:0] err_code_q;

   logic direct;
   logic mode16;
   logic strobe;
   logic start;
   logic busy_o;
   logic idx_wr;
   logic fifo_hit;
   logic push;
   logic pop;
   logic cmd_wr;
   logic abort;
   logic go;
   logic broken;
   logic invalid_odd;
   logic dm_take;
   logic dm_issue;
   logic drain_issue;
   logic core_done;
   logic [31:0] cmd_word;

   // Mode, link edges and indexed decode
   always_comb begin
      direct = iface_sel_i == `PWF_SEL_DIRECT8 || iface_sel_i == `PWF_SEL_DIRECT16;
      mode16 = iface_sel_i == `PWF_SEL_DIRECT16;
      strobe = link.cs && (link.wr || link.rd);
      start = strobe && !strobe_q;
      busy_o = busy_q || want_q;
      idx_wr = start && link.wr && !direct;
      fifo_hit = link.fifo_sel || link.addr[15:5] == `PWF_WR_DATA_BLK;
      push = idx_wr && fifo_hit && cnt_q != (PW+1)'(DEPTH);
      cmd_wr = idx_wr && !link.fifo_sel && link.addr == `PWF_WR_CMD_OFS;
      abort = cmd_wr && link.wdata[`PWF_CMD_ABORT_BIT];
      go = cmd_wr && link.wdata[`PWF_CMD_BUSY_BIT] && !abort;
      core_done = core_req_o && core_ack_i;
      pop = core_done && from_drain_q;
      broken = direct && strobe_q && !strobe && busy_o;
      invalid_odd = mode16 && acc_addr_q[0] && acc_hbe_n_q;
      dm_take = dm_state_q == DM_IDLE && want_q && !broken;
      dm_issue = dm_take && !invalid_odd && acc_addr_q <= `PWF_DM_TOP;
      drain_issue = !direct && xfer_busy_q && cnt_q != '0 && !core_req_o && !abort;
   end

   // Status word: busy, space flag and free count
   always_comb begin
      cmd_word = 32'h0000_0000;
      cmd_word[`PWF_CMD_BUSY_BIT] = xfer_busy_q;
      cmd_word[`PWF_CMD_AVAIL_BIT] = cnt_q != (PW+1)'(DEPTH);
      cmd_word[`PWF_CMD_CNT_LSB +: PW+1] = (PW+1)'(DEPTH) - cnt_q;
   end

   // FIFO storage; a whole word is always stored
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr_q] <= link.wdata;
      end
   end

   // FIFO pointers and fill level; abort empties it
   always_ff @(posedge clk_i) begin
      if (srst_i || abort) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   // Transfer progress: address/length load, advance, self-clear
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cur_addr_q <= 16'h0000;
         cur_len_q <= 16'h0000;
         xfer_busy_q <= 1'b0;
      end else if (abort) begin
         xfer_busy_q <= 1'b0;
      end else begin
         if (idx_wr && !xfer_busy_q && !link.fifo_sel && link.addr == `PWF_WR_ADDR_LEN_OFS) begin
            cur_addr_q <= link.wdata[`PWF_AL_ADDR_LSB +: 16];
            cur_len_q <= link.wdata[`PWF_AL_LEN_LSB +: 16];
         end
         if (go && cur_len_q != 16'h0000) begin
            xfer_busy_q <= 1'b1;
         end
         if (pop) begin
            cur_addr_q <= cur_addr_q + {13'h0000, ones(core_be_o)};
            cur_len_q <= cur_len_q - {13'h0000, ones(core_be_o)};
            if (cur_len_q == {13'h0000, ones(core_be_o)}) begin
               xfer_busy_q <= 1'b0;
            end
         end
      end
   end

   // Core port owner: one request outstanding at a time
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         core_req_o <= 1'b0;
         core_we_o <= 1'b0;
         core_addr_o <= 16'h0000;
         core_be_o <= 4'h0;
         core_wdata_o <= 32'h0000_0000;
         from_drain_q <= 1'b0;
      end else begin
         if (core_done) begin
            core_req_o <= 1'b0;
         end
         if (abort) begin
            from_drain_q <= 1'b0; // late ack must not pop new data
         end
         if (dm_issue) begin
            core_req_o <= 1'b1;
            core_we_o <= acc_we_q;
            core_addr_o <= {acc_addr_q[15:2], 2'b00};
            core_be_o <= dm_lanes(mode16, acc_addr_q[1:0], acc_hbe_n_q);
            // Little-endian: lane k carries byte at address k
            core_wdata_o <= mode16 ? {2{acc_wdata_q[15:0]}} : {4{acc_wdata_q[7:0]}};
            from_drain_q <= 1'b0;
         end else if (drain_issue) begin
            core_req_o <= 1'b1;
            core_we_o <= 1'b1;
            core_addr_o <= {cur_addr_q[15:2], 2'b00};
            core_be_o <= lane_mask(cur_addr_q[1:0], cur_len_q);
            core_wdata_o <= mem[rd_ptr_q];
            from_drain_q <= 1'b1;
         end
      end
   end

   // Host access sequencing, busy handshake and read data
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         strobe_q <= 1'b0;
         want_q <= 1'b0;
         busy_q <= 1'b0;
         abandon_q <= 1'b0;
         acc_we_q <= 1'b0;
         acc_addr_q <= 16'h0000;
         acc_hbe_n_q <= 1'b1;
         acc_wdata_q <= 32'h0000_0000;
         dm_state_q <= DM_IDLE;
         wait_cnt_q <= 4'h0;
         rdata_q <= 32'h0000_0000;
      end else begin
         strobe_q <= strobe;
         if (start) begin
            acc_we_q <= link.wr;
            acc_addr_q <= link.addr;
            acc_hbe_n_q <= link.high_byte_enable_n;
            acc_wdata_q <= link.wdata;
            if (direct) begin
               want_q <= 1'b1;
            end else if (link.rd) begin
               // Indexed reads answer at once; data FIFO reads as zero
               if (link.addr == `PWF_WR_ADDR_LEN_OFS && !link.fifo_sel) begin
                  rdata_q <= {cur_len_q, cur_addr_q};
               end else if (link.addr == `PWF_WR_CMD_OFS && !link.fifo_sel) begin
                  rdata_q <= cmd_word;
               end else begin
                  rdata_q <= 32'h0000_0000;
               end
            end
         end
         case (dm_state_q)
            DM_IDLE: begin
               if (broken) begin
                  want_q <= 1'b0;
               end else if (want_q) begin
                  want_q <= 1'b0;
                  if (dm_issue) begin
                     dm_state_q <= DM_CORE;
                     busy_q <= !(acc_we_q && posted_wr_i);
                  end else if (!acc_we_q) begin
                     // Refused read answers zero; a refused write leaves read data alone
                     rdata_q <= 32'h0000_0000;
                  end
               end
            end
            DM_CORE: begin
               if (broken) begin
                  busy_q <= 1'b0;
                  abandon_q <= !acc_we_q;
               end
               if (core_ack_i) begin
                  // Direction of the issued request; a posted write may overlap a new start
                  if (!core_we_o && !abandon_q && !broken) begin
                     rdata_q <= mode16 ?
                        32'(16'(core_rdata_i >> {acc_addr_q[1], 4'h0})) :
                        32'(8'(core_rdata_i >> {acc_addr_q[1:0], 3'b000}));
                     wait_cnt_q <= rd_wait_i;
                     dm_state_q <= DM_WAIT;
                  end else begin
                     busy_q <= 1'b0;
                     abandon_q <= 1'b0;
                     dm_state_q <= DM_IDLE;
                  end
               end
            end
            DM_WAIT: begin
               if (broken || wait_cnt_q == 4'h0) begin
                  busy_q <= 1'b0;
                  dm_state_q <= DM_IDLE;
               end else begin
                  wait_cnt_q <= wait_cnt_q - 4'h1;
               end
            end
            default: dm_state_q <= DM_IDLE;
         endcase
      end
   end

   // Error counter saturates; code keeps the latest cause
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         err_cnt_q <= 8'h00;
         err_code_q <= 8'h00;
      end else if (broken || (dm_take && invalid_odd)) begin
         if (err_cnt_q != 8'hff) begin
            err_cnt_q <= err_cnt_q + 8'h01;
         end
         if (broken) begin
            err_code_q <= acc_we_q ? `PWF_ERR_WR_BREAK : `PWF_ERR_RD_BREAK;
         end else begin
            err_code_q <= `PWF_ERR_ODD;
         end
      end
   end

   assign link.rdata = rdata_q;
   assign link.busy = busy_o;
   assign link.space_free_flag = !direct && cnt_q != (PW+1)'(DEPTH);
   assign err_count_o = err_cnt_q;
   assign err_code_o = err_code_q;
endmodule

`default_nettype wire

//--- design/pwf_regs.svh
/*
 * Offsets, field positions, codes and sizes shared by both ends of the
 * process RAM write path and its host-side bridge.
 * Assumes byte addresses on a 16-bit host address bus.
 */
`ifndef PWF_REGS_SVH
`define PWF_REGS_SVH

// Write FIFO shape
`define PWF_FIFO_DEPTH 16
`define PWF_FIFO_WIDTH 32

// Indexed register map, byte addresses
`define PWF_WR_DATA_OFS 16'h0020
`define PWF_WR_DATA_BLK 11'h001
`define PWF_WR_ADDR_LEN_OFS 16'h0310
`define PWF_WR_CMD_OFS 16'h0314

// write_start_and_length fields
`define PWF_AL_ADDR_LSB 0
`define PWF_AL_LEN_LSB 16

// write_command_status fields
`define PWF_CMD_BUSY_BIT 31
`define PWF_CMD_ABORT_BIT 30
`define PWF_CMD_AVAIL_BIT 24
`define PWF_CMD_CNT_LSB 16

// Process RAM window and direct-mapped top
`define PWF_RAM_LO 17'h01000
`define PWF_RAM_HI 17'h01fff
`define PWF_DM_TOP 16'h2fff

// interface_select_field encodings
`define PWF_SEL_INDEXED 2'h0
`define PWF_SEL_DIRECT8 2'h1
`define PWF_SEL_DIRECT16 2'h2

// Access error codes
`define PWF_ERR_ODD 8'h01
`define PWF_ERR_WR_BREAK 8'h02
`define PWF_ERR_RD_BREAK 8'h03

// Host bridge register map
`define PWF_H_TGT 8'h00
`define PWF_H_WDATA 8'h04
`define PWF_H_GO 8'h08
`define PWF_H_STAT 8'h0c
`define PWF_H_RDATA 8'h10
`define PWF_TGT_HBE_N_BIT 16
`define PWF_TGT_FIFO_BIT 17
`define PWF_GO_WR_BIT 0
`define PWF_GO_RD_BIT 1
`define PWF_ST_BUSY_BIT 0
`define PWF_ST_REFUSED_BIT 1
`define PWF_ST_SPACE_BIT 2

`endif

//--- design/pwf_pkg.sv
/*
 * Types for the process RAM write path: state machines of both ends.
 * Assumes pwf_regs.svh for all numeric constants.
 */
`default_nettype none

package pwf_pkg;
   // Direct-mapped access sequencer of the device end
   typedef enum logic [1:0] {DM_IDLE, DM_CORE, DM_WAIT} pwf_dm_state_t;
   // Link cycle sequencer of the host end
   typedef enum logic [1:0] {HS_IDLE, HS_HOLD, HS_WAIT} pwf_hs_state_t;
endpackage

`default_nettype wire

//--- design/pwf_link_if.sv
/*
 * Parallel host bus between host bridge and device end.
 * Assumes both ends on one clock; strobes are levels held by the host
 * until busy is low; data in and out run on split buses.
 */
`default_nettype none

interface pwf_link_if;
   logic cs;
   logic wr;
   logic rd;
   logic fifo_sel;
   logic [15:0] addr;
   logic high_byte_enable_n;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic busy;
   logic space_free_flag;

   modport dev (
      input cs, wr, rd, fifo_sel, addr, high_byte_enable_n, wdata,
      output rdata, busy, space_free_flag
   );
   modport host (
      output cs, wr, rd, fifo_sel, addr, high_byte_enable_n, wdata,
      input rdata, busy, space_free_flag
   );
endinterface

`default_nettype wire

//--- design/pwf_host_end.sv
/*
 * Host end: bridges a plain software port onto the parallel host bus.
 * Assumes software on the same clock; read data one cycle after strobe.
 */
`include "pwf_regs.svh"
`default_nettype none

module pwf_host_end
   import pwf_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   pwf_link_if.host link,
   input wire logic direct_i,
   input wire logic [7:0] sw_addr_i,
   input wire logic [31:0] sw_wdata_i,
   input wire logic sw_we_i,
   input wire logic sw_re_i,
   output logic [31:0] sw_rdata_o
);
   pwf_hs_state_t state_q;
   logic [17:0] tgt_q;
   logic [31:0] wdat_q;
   logic [31:0] rdat_q;
   logic refused_q;
   logic armed_q;
   logic cs_q;
   logic wr_q;
   logic rd_q;
   logic go;
   logic go_wr;
   logic is_fifo;
   logic is_al;
   logic is_cmd_start;
   logic [16:0] al_end;
   logic refuse;

   // Screening of a launch against the device's usage rules
   always_comb begin
      go = sw_we_i && sw_addr_i == `PWF_H_GO;
      go_wr = sw_wdata_i[`PWF_GO_WR_BIT];
      is_fifo = tgt_q[`PWF_TGT_FIFO_BIT] || tgt_q[15:5] == `PWF_WR_DATA_BLK;
      is_al = !direct_i && go_wr && !tgt_q[`PWF_TGT_FIFO_BIT] &&
         tgt_q[15:0] == `PWF_WR_ADDR_LEN_OFS;
      is_cmd_start = !direct_i && go_wr && !tgt_q[`PWF_TGT_FIFO_BIT] &&
         tgt_q[15:0] == `PWF_WR_CMD_OFS && wdat_q[`PWF_CMD_BUSY_BIT] &&
         !wdat_q[`PWF_CMD_ABORT_BIT];
      al_end = {1'b0, wdat_q[15:0]} + {1'b0, wdat_q[31:16]} - 17'h00001;
      refuse = state_q != HS_IDLE;
      if (!direct_i && go_wr && is_fifo && !link.space_free_flag) begin
         refuse = 1'b1;
      end
      if (is_al && ({1'b0, wdat_q[15:0]} < `PWF_RAM_LO || wdat_q[31:16] == 16'h0000 ||
            al_end > `PWF_RAM_HI)) begin
         refuse = 1'b1;
      end
      if (is_cmd_start && !armed_q) begin
         refuse = 1'b1;
      end
   end

   // Software-visible target and data registers
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         tgt_q <= 18'h00000;
         wdat_q <= 32'h0000_0000;
      end else if (sw_we_i && state_q == HS_IDLE) begin
         if (sw_addr_i == `PWF_H_TGT) begin
            tgt_q <= sw_wdata_i[17:0];
         end
         if (sw_addr_i == `PWF_H_WDATA) begin
            wdat_q <= sw_wdata_i;
         end
      end
   end

   // Length programmed before each start command
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         armed_q <= 1'b0;
         refused_q <= 1'b0;
      end else if (go) begin
         refused_q <= refuse;
         if (!refuse && is_al) begin
            armed_q <= 1'b1;
         end else if (!refuse && is_cmd_start) begin
            armed_q <= 1'b0;
         end
      end
   end

   // Link cycle: strobe held at least two cycles and until busy drops
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_q <= HS_IDLE;
         cs_q <= 1'b0;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         case (state_q)
            HS_IDLE: begin
               if (go && !refuse && (go_wr || sw_wdata_i[`PWF_GO_RD_BIT])) begin
                  cs_q <= 1'b1;
                  wr_q <= go_wr;
                  rd_q <= !go_wr;
                  state_q <= HS_HOLD;
               end
            end
            HS_HOLD: state_q <= HS_WAIT;
            HS_WAIT: begin
               if (!link.busy) begin
                  if (rd_q) begin
                     rdat_q <= link.rdata;
                  end
                  cs_q <= 1'b0;
                  wr_q <= 1'b0;
                  rd_q <= 1'b0;
                  state_q <= HS_IDLE;
               end
            end
            default: state_q <= HS_IDLE;
         endcase
      end
   end

   // Software read port, one cycle latency
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sw_rdata_o <= 32'h0000_0000;
      end else if (sw_re_i) begin
         case (sw_addr_i)
            `PWF_H_TGT: sw_rdata_o <= {14'h0000, tgt_q};
            `PWF_H_WDATA: sw_rdata_o <= wdat_q;
            `PWF_H_STAT: sw_rdata_o <= {29'h0, link.space_free_flag, refused_q,
               state_q != HS_IDLE};
            `PWF_H_RDATA: sw_rdata_o <= rdat_q;
            default: sw_rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         sw_rdata_o <= 32'h0000_0000;
      end
   end

   assign link.cs = cs_q;
   assign link.wr = wr_q;
   assign link.rd = rd_q;
   assign link.fifo_sel = tgt_q[`PWF_TGT_FIFO_BIT];
   assign link.addr = tgt_q[15:0];
   assign link.high_byte_enable_n = tgt_q[`PWF_TGT_HBE_N_BIT];
   assign link.wdata = wdat_q;
endmodule

`default_nettype wire

//--- test/pwf_link_monitor.sv
/* Link checker: assertions on the parallel host bus between the ends.
   Assumes one clock domain and a synchronous active-high reset. */
`default_nettype none
module pwf_link_monitor (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [1:0] iface_sel_i,
   input wire logic cs,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] addr,
   input wire logic high_byte_enable_n,
   input wire logic [31:0] rdata,
   input wire logic busy,
   input wire logic space_free_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   // Direct-mapped mode selected
   wire logic dm = iface_sel_i inside {2'h1, 2'h2};
   // Strobe rises under chip select
   sequence s_start;
      cs && (wr || rd) && !$past(cs && (wr || rd));
   endsequence
   sequence s_pulse;
      busy ##1 !busy;
   endsequence
   // Mode change may lag a cycle, hence the past term
   AST_DM_NO_SPACE: assert property (dm && $past(dm) |-> !space_free_flag)
      else $error("space flag high in direct mode");
   AST_IDX_NO_BUSY: assert property (s_start ##0 !dm |=> !busy [*2])
      else $error("busy on indexed access");
   AST_DM_BUSY: assert property (s_start ##0 dm |=> busy)
      else $error("direct access without busy");
   AST_ODD_PULSE: assert property (s_start ##0 (iface_sel_i == 2'h2 && addr[0]
      && high_byte_enable_n) |=> s_pulse)
      else $error("odd access busy not one cycle");
   AST_BUSY_ENDS: assert property ($rose(busy) |-> ##[1:60] !busy)
      else $error("busy stuck");
   AST_HOST_HOLDS: assert property (cs && (wr || rd) && busy |=>
      cs && $stable(wr) && $stable(addr))
      else $error("strobe dropped while busy");
   AST_SPACE_FALL: assert property ($fell(space_free_flag) && !dm && !$past(dm)
      |-> $past(cs && wr))
      else $error("space flag fell without a write");
   AST_RDATA_HOLD: assert property (!rd ##1 !rd |-> $stable(rdata))
      else $error("read data moved without a read");
endmodule
`default_nettype wire

//--- test/process_ram_write_fifo_direct_map_bench.sv
/* Bench: host end and device end joined by the link, a random-stall core
   responder and a software port driver. Assumes a 200 MHz clock. */
`include "pwf_regs.svh"
`default_nettype none
module process_ram_write_fifo_direct_map_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'h0, srst_i = 1'h1, direct_i = 1'h0, posted_wr_i = 1'h0;
   logic [1:0] iface_sel_i = 2'h0;
   logic [3:0] rd_wait_i = 4'h0;
   logic [7:0] sw_addr_i = 8'h00;
   logic [31:0] sw_wdata_i = 32'h0, core_rdata_i = 32'h0, sw_rdata_o, d;
   logic sw_we_i = 1'h0, sw_re_i = 1'h0, chk_q = 1'h0, rd_q = 1'h0;
   logic core_ack_i = 1'h0, core_req_o, core_we_o;
   logic [15:0] core_addr_o, a;
   logic [3:0] core_be_o;
   logic [31:0] core_wdata_o;
   logic [7:0] err_count_o, err_code_o;
   logic [31:0] rq[$];
   logic [51:0] cq[$];
   int fail_count = 0, check_count = 0;
   pwf_link_if lk();
   pwf_host_end i_pwf_host_end(.clk_i(clk_i), .srst_i(srst_i), .link(lk),
      .direct_i(direct_i), .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i),
      .sw_we_i(sw_we_i), .sw_re_i(sw_re_i), .sw_rdata_o(sw_rdata_o));
   pwf_dev_end #(.DEPTH(16)) i_pwf_dev_end(.clk_i(clk_i), .srst_i(srst_i),
      .link(lk), .iface_sel_i(iface_sel_i), .posted_wr_i(posted_wr_i),
      .rd_wait_i(rd_wait_i), .core_req_o(core_req_o), .core_we_o(core_we_o),
      .core_addr_o(core_addr_o), .core_be_o(core_be_o),
      .core_wdata_o(core_wdata_o), .core_ack_i(core_ack_i),
      .core_rdata_i(core_rdata_i), .err_count_o(err_count_o),
      .err_code_o(err_code_o));
   pwf_link_monitor i_pwf_link_monitor(.clk_i(clk_i), .srst_i(srst_i),
      .iface_sel_i(iface_sel_i), .cs(lk.cs), .wr(lk.wr), .rd(lk.rd),
      .addr(lk.addr), .high_byte_enable_n(lk.high_byte_enable_n),
      .rdata(lk.rdata), .busy(lk.busy), .space_free_flag(lk.space_free_flag));
   always #2.5 clk_i = ~clk_i;
   // Core: random stall keeps the drain honest
   always @(posedge clk_i) begin
      core_ack_i <= core_req_o && !core_ack_i && ($urandom % 2 == 0);
      core_rdata_i <= $urandom;
      // Only direct read is a 16-bit word at lane 0: low half, little-endian
      if (core_req_o && core_ack_i && !core_we_o) rq.push_back({16'h0, core_rdata_i[15:0]});
   end
   task automatic cmp(input string nm, input logic [51:0] e, input logic [51:0] s);
      check_count++;
      if (e !== s) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Result watcher: oldest note against each result
   always @(posedge clk_i) begin
      rd_q <= sw_re_i && chk_q;
      if (rd_q)
         cmp("sw_rdata", 52'(rq.pop_front()), 52'(sw_rdata_o));
      if (core_req_o && core_ack_i && core_we_o)
         cmp("core_wr", cq.pop_front(), {core_addr_o, core_be_o, core_wdata_o});
   end
   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic sw(input logic we, input logic [7:0] ad, input logic [31:0] dt,
      input logic c);
      @(posedge clk_i);
      sw_we_i <= we;
      sw_re_i <= !we;
      chk_q <= c;
      sw_addr_i <= ad;
      sw_wdata_i <= dt;
      @(posedge clk_i);
      sw_we_i <= 1'h0;
      sw_re_i <= 1'h0;
   endtask
   // One link cycle, then poll until the host end is idle
   task automatic link(input logic [17:0] t, input logic [31:0] dt, input logic [1:0] go);
      sw(1'h1, `PWF_H_TGT, {14'h0, t}, 1'h0);
      sw(1'h1, `PWF_H_WDATA, dt, 1'h0);
      sw(1'h1, `PWF_H_GO, {30'h0, go}, 1'h0);
      repeat (80) begin
         sw(1'h0, `PWF_H_STAT, 32'h0, 1'h0);
         @(posedge clk_i);
         if (sw_rdata_o[0] === 1'h0)
            break;
      end
   endtask
   task automatic lrd(input logic [15:0] ad, input logic [31:0] e);
      link({2'h0, ad}, 32'h0, 2'h2);
      rq.push_back(e);
      sw(1'h0, `PWF_H_RDATA, 32'h0, 1'h1);
   endtask
   // Lanes from start lane in the first word to end lane in the last
   task automatic xfer(input logic [15:0] n, input logic fs);
      int w, lo, hi;
      w = (a[1:0] + n + 3) / 4;
      link({2'h0, 16'h0310}, {n, a}, 2'h1);
      link({2'h0, 16'h0314}, 32'h8000_0000, 2'h1);
      for (int k = 0; k < w; k++) begin
         d = $urandom;
         lo = (k == 0) ? a[1:0] : 0;
         hi = (k == w - 1) ? (a[1:0] + n - 1) % 4 : 3;
         cq.push_back({(a & 16'hfffc) + 16'(4 * k), 4'((15 << lo) & (15 >> (3 - hi))), d});
         link({fs, 1'h0, fs ? 16'($urandom) : 16'h0020 + 16'(4 * (k % 8))}, d, 2'h1);
      end
      repeat (40) @(posedge clk_i);
      lrd(16'h0314, 32'h0110_0000);
      lrd(16'h0310, {16'h0, a + n});
   endtask
   initial begin
      void'($urandom(50425));
      repeat (12) @(posedge clk_i);
      srst_i <= 1'h0;
      rd_wait_i <= 4'($urandom % 4);
      posted_wr_i <= 1'($urandom % 2);
      lrd(16'h0314, 32'h0110_0000);
      for (int i = 0; i < 8; i++) begin
         a = 16'h1000 + 16'($urandom % 200);
         xfer(16'(1 + $urandom % 24), 1'(i % 2));
      end
      // Abort of a pending command
      link({2'h0, 16'h0310}, {16'h0028, 16'h1100}, 2'h1);
      link({2'h0, 16'h0314}, 32'h8000_0000, 2'h1);
      lrd(16'h0314, 32'h8110_0000);
      link({2'h0, 16'h0314}, 32'h4000_0000, 2'h1);
      lrd(16'h0314, 32'h0110_0000);
      // Fill until refused, then flush
      for (int k = 0; k < 16; k++)
         link({2'h0, 16'h0020}, 32'(k), 2'h1);
      lrd(16'h0314, 32'h0);
      link({2'h0, 16'h0020}, 32'h0, 2'h1);
      rq.push_back(32'h2);
      sw(1'h0, `PWF_H_STAT, 32'h0, 1'h1);
      link({2'h0, 16'h0314}, 32'h4000_0000, 2'h1);
      lrd(16'h0314, 32'h0110_0000);
      // Direct mapped, 16-bit lanes
      iface_sel_i <= 2'h2;
      direct_i <= 1'h1;
      d = $urandom;
      cq.push_back({16'h1000, 4'hc, {2{d[15:0]}}});
      link({2'h0, 16'h1002}, d, 2'h1);
      cq.push_back({16'h1000, 4'h8, {2{d[15:0]}}});
      link({2'h0, 16'h1003}, d, 2'h1);
      cq.push_back({16'h1004, 4'h1, {2{d[15:0]}}});
      link({2'h1, 16'h1004}, d, 2'h1);
      link({2'h1, 16'h1001}, d, 2'h1);
      cmp("err_code", 52'(`PWF_ERR_ODD), 52'(err_code_o));
      cmp("err_count", 52'h1, 52'(err_count_o));
      link({2'h0, 16'h1004}, 32'h0, 2'h2);
      sw(1'h0, `PWF_H_RDATA, 32'h0, 1'h1);
      // Direct mapped, 8-bit lanes, CSR and direct-mapped top
      iface_sel_i <= 2'h1;
      for (int k = 0; k < 4; k++) begin
         cq.push_back({16'h0010, 4'(1 << k), {4{d[7:0]}}});
         link({2'h0, 16'h0010 + 16'(k)}, d, 2'h1);
      end
      cq.push_back({16'h2ffc, 4'h8, {4{d[7:0]}}});
      link({2'h0, 16'h2fff}, d, 2'h1);
      repeat (20) @(posedge clk_i);
      cmp("core_left", 52'h0, 52'(cq.size()));
      end_of_test();
   end
   // Watchdog against a hung handshake
   initial begin
      #200000;
      fail_count++;
      end_of_test();
   end
endmodule
`default_nettype wire
